// *** common/rtchw_params.svh ***
`ifndef RTCHW_PARAMS_SVH
`define RTCHW_PARAMS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define RTCHW_OFF_HOUR      12'h000
`define RTCHW_OFF_WEEKDAY   12'h004
`define RTCHW_OFF_CTRL      12'h008
`define RTCHW_OFF_STATUS    12'h00c
// ****************************************
// Field positions
// ****************************************
`define RTCHW_BIT_BUSY      7
`define RTCHW_BIT_RUN       7
`define RTCHW_BIT_MODE24    6
`define RTCHW_BIT_AFTERNOON 5
`define RTCHW_BIT_CARRY     0
// ****************************************
// Limits and reset values
// ****************************************
`define RTCHW_HOUR_MAX12    8'h11
`define RTCHW_HOUR_MAX24    8'h23
`define RTCHW_WK_MAX        3'h6
`define RTCHW_HOUR_RST      6'h00
`define RTCHW_WK_RST        3'h0
`define RTCHW_BUSY_CYCLES   4'h2
`endif

// *** common/rtchw_pkg.sv ***
package rtchw_pkg;
    // BCD hour split into tens and units digits
    typedef struct packed {
        logic [1:0] tens;
        logic [3:0] units;
    } rtchw_hour_t;
    // Register bus write request
    typedef struct packed {
        logic        en;
        logic [11:0] addr;
        logic [31:0] data;
    } rtchw_wr_t;
    // Update sequencer states
    typedef enum logic [1:0] {
        RTCHW_IDLE = 2'b00,
        RTCHW_BUSY = 2'b01
    } rtchw_state_t;
endpackage

// *** core/rtchw_hour_stage.sv ***
`include "rtchw_params.svh"
// Hour counter: BCD, wraps at 11 or 23, emits daily carry
module rtchw_hour_stage (
    input  wire logic                 mclk,
    input  wire logic                 nrst,
    input  wire logic                 step,
    input  wire logic                 mode24,
    input  wire logic                 wr_en,
    input  wire logic [5:0]           wr_data,
    output rtchw_pkg::rtchw_hour_t    hour_reg,
    output logic                      day_carry_reg
);
    logic [7:0] hour_bcd;   // Flat view for limit compare
    logic [7:0] hour_max;   // Selected wrap limit
    assign hour_bcd = {2'h0, hour_reg};
    assign hour_max = mode24 ? `RTCHW_HOUR_MAX24 : `RTCHW_HOUR_MAX12;

    // ****************************************
    // Hour count
    // ****************************************
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            hour_reg <= `RTCHW_HOUR_RST;
        end else if (wr_en) begin
            // Software write wins over a carry in the same cycle
            hour_reg <= wr_data;
        end else if (step) begin
            if (hour_bcd >= hour_max) begin
                hour_reg <= `RTCHW_HOUR_RST;
            end else if (hour_reg.units >= 4'h9) begin
                hour_reg.units <= 4'h0;
                hour_reg.tens  <= hour_reg.tens + 2'h1;
            end else begin
                hour_reg.units <= hour_reg.units + 4'h1;
            end
        end
    end

    // Daily carry pulse, one cycle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            day_carry_reg <= 1'b0;
        end else begin
            day_carry_reg <= step && !wr_en && (hour_bcd >= hour_max);
        end
    end
endmodule

// *** core/rtchw_week_stage.sv ***
`include "rtchw_params.svh"
// Weekday counter: binary 0..6
module rtchw_week_stage (
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic       step,
    input  wire logic       wr_en,
    input  wire logic [2:0] wr_data,
    output logic      [2:0] wk_reg
);
    // ****************************************
    // Weekday count
    // ****************************************
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wk_reg <= `RTCHW_WK_RST;
        end else if (wr_en) begin
            wk_reg <= wr_data;
        end else if (step) begin
            if (wk_reg >= `RTCHW_WK_MAX) begin
                wk_reg <= 3'h0;
            end else begin
                wk_reg <= wk_reg + 3'h1;
            end
        end
    end
endmodule

// *** core/rtchw_top.sv ***
// What this block does
// - Hour advances in BCD on minute carry
// - Hour range 00-11 or 00-23 by mode
// - Bit 7 of both registers shows busy
// - Hour bit 6 reads zero
// - Hour tens in bits 5:4, 0-2, RW
// - Hour units in bits 3:0, 0-9, RW
// - Units past 9 bumps tens
// - Weekday advances on daily carry; in 12h mode only on the evening wrap, not the noon one
// - Weekday in bits 2:0, 0-6, RW
// - Weekday binary, Sunday 000 to Saturday 110
// - Weekday bits 6:3 read zero
// - Mode bit 0 is 12h, 1 is 24h
// - Afternoon flag 1 for pm in 12h
// - Counting only while run bit is 1
`include "rtchw_params.svh"
module rtchw_top (
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic        minute_carry,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             day_carry_out
);
    // ****************************************
    // Control and status
    // ****************************************
    logic                     run_reg;      // Run control
    logic                     mode24_reg;   // 12/24 select
    logic                     afternoon_flag_reg; // Afternoon flag
    logic                     busy_reg;     // Update in progress
    logic                     carry_seen_reg; // Sticky day carry seen
    logic [3:0]               busy_cnt_reg; // Busy window count
    rtchw_pkg::rtchw_state_t  state_reg;    // Update sequencer
    rtchw_pkg::rtchw_wr_t     wr;           // Decoded write
    logic                     hour_step;    // Gated hourly tick
    logic                     wr_hour;      // Hour register write
    logic                     wr_wk;        // Weekday register write
    rtchw_pkg::rtchw_hour_t   hour_q;       // Hour count
    logic                     day_carry;    // Daily carry pulse
    logic                     day_step;     // Day boundary seen by weekday
    logic [2:0]               wk_q;         // Weekday count
    logic                     access;       // APB access phase
    logic                     mapped;       // Address hits a register
    logic [31:0]              rdata_next;   // Read mux

    assign access = psel && penable;
    assign wr.en = access && pwrite;
    assign wr.addr = paddr;
    assign wr.data = pwdata;
    assign wr_hour = wr.en && (wr.addr == `RTCHW_OFF_HOUR);
    assign wr_wk = wr.en && (wr.addr == `RTCHW_OFF_WEEKDAY);
    // Stopped clock ignores carries entirely
    assign hour_step = minute_carry && run_reg;
    // In 12h mode only the evening wrap ends a day; the noon wrap does not
    assign day_step = day_carry && run_reg && (mode24_reg || afternoon_flag_reg);

    // ****************************************
    // Counter stages
    // ****************************************
    rtchw_hour_stage u_hour (
        .mclk          (mclk),
        .nrst          (nrst),
        .step          (hour_step),
        .mode24        (mode24_reg),
        .wr_en         (wr_hour),
        .wr_data       (wr.data[5:0]),
        .hour_reg      (hour_q),
        .day_carry_reg (day_carry)
    );

    rtchw_week_stage u_week (
        .mclk    (mclk),
        .nrst    (nrst),
        .step    (day_step),
        .wr_en   (wr_wk),
        .wr_data (wr.data[2:0]),
        .wk_reg  (wk_q)
    );

    // ****************************************
    // Control register
    // ****************************************
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            run_reg    <= 1'b0;
            mode24_reg <= 1'b0;
        end else if (wr.en && wr.addr == `RTCHW_OFF_CTRL) begin
            run_reg    <= wr.data[`RTCHW_BIT_RUN];
            mode24_reg <= wr.data[`RTCHW_BIT_MODE24];
        end
    end

    // Afternoon flag toggles on each 12h wrap
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            afternoon_flag_reg <= 1'b0;
        end else if (wr.en && wr.addr == `RTCHW_OFF_CTRL) begin
            afternoon_flag_reg <= wr.data[`RTCHW_BIT_AFTERNOON];
        end else if (day_carry && !mode24_reg) begin
            // Half-day wrap flips morning/afternoon in 12h mode
            afternoon_flag_reg <= !afternoon_flag_reg;
        end
    end

    // Sticky daily carry seen; set wins over a clearing write
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            carry_seen_reg <= 1'b0;
        end else if (day_step) begin
            carry_seen_reg <= 1'b1;
        end else if (wr.en && wr.addr == `RTCHW_OFF_STATUS && wr.data[`RTCHW_BIT_CARRY]) begin
            carry_seen_reg <= 1'b0;
        end
    end

    // ****************************************
    // Busy window around each update
    // ****************************************
    // Busy rises with the tick and covers the ripple into weekday
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_reg    <= rtchw_pkg::RTCHW_IDLE;
            busy_reg     <= 1'b0;
            busy_cnt_reg <= 4'h0;
        end else begin
            case (state_reg)
                rtchw_pkg::RTCHW_IDLE: begin
                    if (hour_step) begin
                        state_reg    <= rtchw_pkg::RTCHW_BUSY;
                        busy_reg     <= 1'b1;
                        busy_cnt_reg <= `RTCHW_BUSY_CYCLES;
                    end
                end
                rtchw_pkg::RTCHW_BUSY: begin
                    if (busy_cnt_reg == 4'h0) begin
                        state_reg <= rtchw_pkg::RTCHW_IDLE;
                        busy_reg  <= 1'b0;
                    end else begin
                        busy_cnt_reg <= busy_cnt_reg - 4'h1;
                    end
                end
                default: begin
                    state_reg <= rtchw_pkg::RTCHW_IDLE;
                    busy_reg  <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // APB read side
    // ****************************************
    always_comb begin
        rdata_next = 32'h0000_0000;
        mapped = 1'b1;
        case (paddr)
            `RTCHW_OFF_HOUR:    rdata_next = {24'h0, busy_reg, 1'b0, hour_q};
            `RTCHW_OFF_WEEKDAY: rdata_next = {24'h0, busy_reg, 4'h0, wk_q};
            `RTCHW_OFF_CTRL:    rdata_next = {24'h0, run_reg, mode24_reg, afternoon_flag_reg, 5'h00};
            `RTCHW_OFF_STATUS:  rdata_next = {31'h0, carry_seen_reg};
            default:            mapped = 1'b0;
        endcase
    end

    // No wait state: ready in the first access cycle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pready  <= 1'b1;
            prdata  <= pwrite ? 32'h0000_0000 : rdata_next;
            pslverr <= !mapped;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Daily carry exported for later stages
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            day_carry_out <= 1'b0;
        end else begin
            day_carry_out <= day_step;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    property p_hour_wrap;
        @(posedge mclk) disable iff (!nrst)
        (hour_step && !wr_hour && !mode24_reg && hour_q == 6'h11) |=> (hour_q == 6'h00 && day_carry);
    endproperty
    a_hour_wrap: assert property (p_hour_wrap) else $error("Hour did not wrap at 11");

    property p_hour_wrap24;
        @(posedge mclk) disable iff (!nrst)
        (hour_step && !wr_hour && mode24_reg && hour_q == 6'h23) |=> (hour_q == 6'h00);
    endproperty
    a_hour_wrap24: assert property (p_hour_wrap24) else $error("Hour did not wrap at 23");

    property p_units_roll;
        @(posedge mclk) disable iff (!nrst)
        (hour_step && !wr_hour && hour_q == 6'h09) |=> (hour_q == 6'h10);
    endproperty
    a_units_roll: assert property (p_units_roll) else $error("Units did not carry into tens");

    property p_hour_inc;
        @(posedge mclk) disable iff (!nrst)
        (hour_step && !wr_hour && hour_q == 6'h04) |=> (hour_q == 6'h05);
    endproperty
    a_hour_inc: assert property (p_hour_inc) else $error("Hour did not advance");

    property p_stopped;
        @(posedge mclk) disable iff (!nrst)
        (!run_reg && !wr_hour) |=> $stable(hour_q);
    endproperty
    a_stopped: assert property (p_stopped) else $error("Hour moved while stopped");

    property p_wk_wrap;
        @(posedge mclk) disable iff (!nrst)
        (day_step && !wr_wk && wk_q == 3'h6) |=> (wk_q == 3'h0);
    endproperty
    a_wk_wrap: assert property (p_wk_wrap) else $error("Weekday did not wrap");

    property p_wk_step;
        @(posedge mclk) disable iff (!nrst)
        (day_step && !wr_wk && wk_q == 3'h2) |=> (wk_q == 3'h3);
    endproperty
    a_wk_step: assert property (p_wk_step) else $error("Weekday did not advance");

    property p_busy;
        @(posedge mclk) disable iff (!nrst)
        (hour_step && state_reg == rtchw_pkg::RTCHW_IDLE) |=> busy_reg [*3] ##1 !busy_reg;
    endproperty
    a_busy: assert property (p_busy) else $error("Busy window wrong");

    property p_afternoon_flip;
        @(posedge mclk) disable iff (!nrst)
        (day_carry && !mode24_reg && !(wr.en && wr.addr == `RTCHW_OFF_CTRL))
            |=> (afternoon_flag_reg != $past(afternoon_flag_reg));
    endproperty
    a_afternoon_flip: assert property (p_afternoon_flip) else $error("Afternoon flag did not flip");

    property p_ready;
        @(posedge mclk) disable iff (!nrst)
        (psel && !penable) |=> pready ##1 !pready;
    endproperty
    a_ready: assert property (p_ready) else $error("APB ready timing wrong");

    // Noon wrap in 12h mode leaves the weekday alone
    property p_noon_hold;
        @(posedge mclk) disable iff (!nrst)
        (day_carry && !mode24_reg && !afternoon_flag_reg && !wr_wk) |=> $stable(wk_q);
    endproperty
    a_noon_hold: assert property (p_noon_hold) else $error("Weekday moved on the noon wrap");

    // Stopped clock also freezes the weekday
    property p_wk_stopped;
        @(posedge mclk) disable iff (!nrst)
        (!run_reg && !wr_wk) |=> $stable(wk_q);
    endproperty
    a_wk_stopped: assert property (p_wk_stopped) else $error("Weekday moved while stopped");

    // Daily carry never lasts two cycles
    property p_day_pulse;
        @(posedge mclk) disable iff (!nrst)
        day_carry |=> !day_carry;
    endproperty
    a_day_pulse: assert property (p_day_pulse) else $error("Daily carry wider than one cycle");

    // Exported carry follows each real day boundary
    property p_day_out;
        @(posedge mclk) disable iff (!nrst)
        day_step |=> day_carry_out;
    endproperty
    a_day_out: assert property (p_day_out) else $error("Daily carry not exported");

    // Software write lands in both hour digits
    property p_hour_write;
        @(posedge mclk) disable iff (!nrst)
        wr_hour |=> ({26'h0, hour_q} == ($past(pwdata) & 32'h0000_003f));
    endproperty
    a_hour_write: assert property (p_hour_write) else $error("Hour write not stored");

    // Software write lands in the weekday field
    property p_wk_write;
        @(posedge mclk) disable iff (!nrst)
        wr_wk |=> ({29'h0, wk_q} == ($past(pwdata) & 32'h0000_0007));
    endproperty
    a_wk_write: assert property (p_wk_write) else $error("Weekday write not stored");

    // Hour read shows the busy flag of its setup cycle
    property p_busy_bit;
        @(posedge mclk) disable iff (!nrst)
        (psel && !penable && !pwrite && paddr == `RTCHW_OFF_HOUR) |=> (prdata[7] == $past(busy_reg));
    endproperty
    a_busy_bit: assert property (p_busy_bit) else $error("Hour read busy bit wrong");

    // Reserved hour bit reads zero
    property p_hour_rsv;
        @(posedge mclk) disable iff (!nrst)
        (psel && !penable && !pwrite && paddr == `RTCHW_OFF_HOUR) |=> (prdata[6] == 1'b0);
    endproperty
    a_hour_rsv: assert property (p_hour_rsv) else $error("Hour reserved bit not zero");

    // Reserved weekday bits read zero, busy shown on top
    property p_wk_rsv;
        @(posedge mclk) disable iff (!nrst)
        (psel && !penable && !pwrite && paddr == `RTCHW_OFF_WEEKDAY)
            |=> (prdata[6:3] == 4'h0 && prdata[7] == $past(busy_reg));
    endproperty
    a_wk_rsv: assert property (p_wk_rsv) else $error("Weekday reserved bits wrong");

    // Only the low byte of any word carries data
    property p_rd_upper;
        @(posedge mclk) disable iff (!nrst)
        (psel && !penable && !pwrite) |=> (prdata[31:8] == 24'h0);
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("Read data upper bits not zero");

    // Unmapped place answers with an error
    property p_err;
        @(posedge mclk) disable iff (!nrst)
        (psel && !penable && !mapped) |=> (pslverr && pready);
    endproperty
    a_err: assert property (p_err) else $error("Unmapped access not refused");

    // ****************************************
    // Cover points
    // ****************************************
    c_wrap12: cover property (@(posedge mclk) disable iff (!nrst) day_carry && !mode24_reg);
    c_wrap24: cover property (@(posedge mclk) disable iff (!nrst) day_carry && mode24_reg);
    c_wk_wrap: cover property (@(posedge mclk) disable iff (!nrst) day_step && wk_q == 3'h6);
    c_noon: cover property (@(posedge mclk) disable iff (!nrst) day_carry && !day_step);
endmodule

// *** verif/test_rtc_hour_weekday_counters.sv ***
`include "rtchw_params.svh"
module test_rtc_hour_weekday_counters;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Design ports and bench state
    // ****************************************
    logic        mclk;           // 125 MHz clock
    logic        nrst;           // Async reset, active low
    logic        minute_carry;   // Hourly tick
    logic        psel;           // Bus select
    logic        penable;        // Bus access phase
    logic        pwrite;         // Bus direction
    logic [11:0] paddr;          // Byte address
    logic [31:0] pwdata;         // Write data
    logic [31:0] prdata;         // Read data
    logic        pready;         // Bus answer
    logic        pslverr;        // Bus error
    logic        day_carry_out;  // Daily carry pulse
    int          bad_count;      // Mismatches
    int          checks_done;    // Comparisons made
    int          day_pulses;     // Daily carries seen
    logic        last_err;       // Error of last transfer
    logic [31:0] rd_val;         // Last read word
    logic        busy_seen;      // Busy caught while updating

    rtchw_top u_rtchw_top (
        .mclk          (mclk),
        .nrst          (nrst),
        .minute_carry  (minute_carry),
        .psel          (psel),
        .penable       (penable),
        .pwrite        (pwrite),
        .paddr         (paddr),
        .pwdata        (pwdata),
        .prdata        (prdata),
        .pready        (pready),
        .pslverr       (pslverr),
        .day_carry_out (day_carry_out)
    );

    // Free-running clock, 8 ns period
    always #4 mclk = ~mclk;

    // Count daily carry pulses as they stand
    always @(posedge mclk) begin
        if (day_carry_out === 1'b1) begin
            day_pulses++;
        end
    end

    // ****************************************
    // Bus and compare tasks
    // ****************************************
    // One transfer; request held until pready sampled high
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r        = prdata;
        last_err = pslverr;
        // A transfer that never answers is a mismatch
        if (pready !== 1'b1) begin
            bad_count++;
            $display("wrong value pready expected 1 seen %b", pready);
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        // One idle edge, so a following call never drives psel twice in a step
        @(posedge mclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(a, 1'b1, d, r);
    endtask

    task automatic rd(input logic [11:0] a);
        xfer(a, 1'b0, 32'h0, rd_val);
    endtask

    // Word compare; unknown bits never match
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Hourly tick, then let the update settle
    task automatic tick(input int settle);
        minute_carry <= 1'b1;
        @(posedge mclk);
        minute_carry <= 1'b0;
        repeat (settle) @(posedge mclk);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        mclk = 1'b0;
        nrst = 1'b0;
        minute_carry = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        bad_count = 0;
        checks_done = 0;
        day_pulses = 0;
        busy_seen = 1'b0;
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        // Reset state: zero time, Sunday, stopped
        rd(`RTCHW_OFF_HOUR);
        check("hour rst", 32'h0, rd_val);
        rd(`RTCHW_OFF_WEEKDAY);
        check("wk rst", 32'h0, rd_val);
        // Unmapped place answers with error and zero
        rd(12'h010);
        check("unmapped err", 32'h1, {31'h0, last_err});
        check("unmapped data", 32'h0, rd_val);
        // Reserved and busy bits ignore writes
        wr(`RTCHW_OFF_HOUR, 32'hffff_ffd5);
        rd(`RTCHW_OFF_HOUR);
        check("hour rw", 32'h15, rd_val);
        wr(`RTCHW_OFF_WEEKDAY, 32'hffff_fffd);
        rd(`RTCHW_OFF_WEEKDAY);
        check("wk rw", 32'h05, rd_val);
        // Stopped clock ignores ticks
        wr(`RTCHW_OFF_HOUR, 32'h11);
        tick(5);
        rd(`RTCHW_OFF_HOUR);
        check("hour stopped", 32'h11, rd_val);
        // Noon wrap in 12h: hour to 00, afternoon set, same day
        wr(`RTCHW_OFF_CTRL, 32'h80);
        tick(5);
        rd(`RTCHW_OFF_HOUR);
        check("hour wrap12", 32'h00, rd_val);
        rd(`RTCHW_OFF_WEEKDAY);
        check("wk noon", 32'h05, rd_val);
        rd(`RTCHW_OFF_CTRL);
        check("afternoon set", 32'ha0, rd_val);
        // Midnight wrap in 12h: afternoon clears, weekday steps
        wr(`RTCHW_OFF_HOUR, 32'h11);
        tick(5);
        rd(`RTCHW_OFF_WEEKDAY);
        check("wk step", 32'h06, rd_val);
        rd(`RTCHW_OFF_CTRL);
        check("afternoon clear", 32'h80, rd_val);
        rd(`RTCHW_OFF_STATUS);
        check("carry sticky", 32'h1, rd_val & 32'h1);
        wr(`RTCHW_OFF_STATUS, 32'h1);
        rd(`RTCHW_OFF_STATUS);
        check("carry clear", 32'h0, rd_val & 32'h1);
        // 24-hour mode: 11 is not the limit
        wr(`RTCHW_OFF_CTRL, 32'hc0);
        wr(`RTCHW_OFF_HOUR, 32'h11);
        tick(5);
        rd(`RTCHW_OFF_HOUR);
        check("hour 24 past 11", 32'h12, rd_val);
        wr(`RTCHW_OFF_HOUR, 32'h04);
        tick(5);
        rd(`RTCHW_OFF_HOUR);
        check("hour step", 32'h05, rd_val);
        // Units digit carry into tens; busy caught mid-update
        wr(`RTCHW_OFF_HOUR, 32'h09);
        tick(0);
        rd(`RTCHW_OFF_HOUR);
        busy_seen = rd_val[7];
        rd(`RTCHW_OFF_WEEKDAY);
        busy_seen = busy_seen | rd_val[7];
        check("busy seen", 32'h1, {31'h0, busy_seen});
        repeat (5) @(posedge mclk);
        rd(`RTCHW_OFF_HOUR);
        check("hour bcd carry", 32'h10, rd_val);
        // Saturday wraps to Sunday at 23 -> 00
        wr(`RTCHW_OFF_HOUR, 32'h23);
        tick(5);
        rd(`RTCHW_OFF_HOUR);
        check("hour wrap24", 32'h00, rd_val);
        rd(`RTCHW_OFF_WEEKDAY);
        check("wk wrap", 32'h00, rd_val);
        // Mid-week day step from Tuesday
        wr(`RTCHW_OFF_WEEKDAY, 32'h02);
        wr(`RTCHW_OFF_HOUR, 32'h23);
        tick(5);
        rd(`RTCHW_OFF_WEEKDAY);
        check("wk mid step", 32'h03, rd_val);
        check("day pulses", 32'h3, 32'(day_pulses));
        end_sim();
    end

    // Watchdog far beyond the expected run length
    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        end_sim();
    end
endmodule
